// ---- inc/ucr_pkg.sv ----
`default_nettype none
package ucr_pkg;
	// Register offsets on the three address lines
	localparam logic [2:0] OFS_HOLD = 3'h0;
	localparam logic [2:0] OFS_IEN = 3'h1;
	localparam logic [2:0] OFS_ISTAT = 3'h2;
	localparam logic [2:0] OFS_LCTL = 3'h3;
	localparam logic [2:0] OFS_MCTL = 3'h4;
	localparam logic [2:0] OFS_LSTAT = 3'h5;
	localparam logic [2:0] OFS_MSTAT = 3'h6;
	localparam logic [2:0] OFS_SCR = 3'h7;
	// Line control key and bit positions
	localparam logic [7:0] ENH_KEY = 8'hBF;
	localparam int DIV_BIT = 7;
	localparam int ENH_BIT = 4;
	localparam int FIFO_EN_BIT = 0;
	localparam int IEN_RX = 0;
	localparam int IEN_TX = 1;
	localparam int IEN_LINE = 2;
	localparam int IEN_MODEM = 3;
	// Bits that only move while the enhanced unlock is set
	localparam logic [7:0] IEN_ENH = 8'hF0;
	localparam logic [7:0] FCTL_ENH = 8'h30;
	localparam logic [7:0] MCTL_ENH = 8'hE0;
	localparam logic [7:0] FRAC_MASK = 8'h3F;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Interrupt source codes, highest priority first
	localparam logic [3:0] SRC_LINE = 4'h6;
	localparam logic [3:0] SRC_RX = 4'h4;
	localparam logic [3:0] SRC_TX = 4'h2;
	localparam logic [3:0] SRC_MODEM = 4'h0;
	localparam logic [3:0] SRC_NONE = 4'h1;
	localparam int FILL_W = 6;
	localparam logic [FILL_W-1:0] FILL_EMPTY = 6'h0;

	typedef struct packed {
		logic cs_a_n;
		logic cs_b_n;
		logic rd_n;
		logic wr_n;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ucr_host_t;
	localparam ucr_host_t HOST_IDLE = '1;

	typedef struct packed {
		logic [FILL_W-1:0] fill;
		logic [FILL_W-1:0] trig;
		logic push;
		logic [7:0] rx_data;
		logic tx_empty;
		logic tx_idle;
		logic fifo_err;
		logic [3:0] line_err;
		logic [7:0] modem;
	} ucr_chan_in_t;

	typedef struct packed {
		logic [7:0] interrupt_enable;
		logic [7:0] fifo_control;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] divisor_low;
		logic [7:0] divisor_high;
		logic [7:0] divisor_fraction;
		logic [7:0] enhanced_function;
		logic [7:0] flow_on_char_1;
		logic [7:0] flow_on_char_2;
		logic [7:0] flow_off_char_1;
		logic [7:0] flow_off_char_2;
		logic [7:0] scratch_pad;
	} ucr_cfg_t;

	typedef struct packed {
		logic rx_pop;
		logic tx_load;
		logic fifo_load;
		logic [7:0] wdata;
	} ucr_strb_t;

	typedef struct packed {
		ucr_cfg_t cfg;
		ucr_strb_t strb;
		logic [7:0] rdata;
		logic dr;
		logic rxi;
		logic irq;
	} ucr_chan_st_t;

	typedef struct packed {
		ucr_host_t s1;
		ucr_host_t s2;
		ucr_host_t s3;
		logic rd_lvl;
		logic wr_lvl;
	} ucr_top_st_t;
endpackage : ucr_pkg
`default_nettype wire

// ---- logic/ucr_top.sv ----
// What this block does
// R1: Each channel decodes three address bits, and a per-channel select picks the channel.
// R2: The interrupt enable gates rx data, tx empty, line and modem sources into the status.
// R3: With FIFO and rx interrupt on, the rx interrupt rises once fill reaches the trigger.
// R4: That rx interrupt drops on the clock after fill falls below the trigger.
// R5: Unless a line interrupt outranks it, the status shows the rx trigger source while fill is at or above it and clears with it.
// R6: Rx data ready sets on the clock after a character enters the receive FIFO.
// R7: Rx data ready clears only when the receive FIFO is empty.
// R8: Enhanced bits of enable, FIFO control, modem control and fraction move only when unlocked.
// R9: Divisor latch at offsets 0 to 2 when divisor bit set, enhanced set when key 0xBF.
`timescale 1ns/10ps
`default_nettype none
module ucr_chan #(
	parameter logic [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
	parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic rd_go,
	input wire logic wr_go,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire ucr_pkg::ucr_chan_in_t chan_in,
	output ucr_pkg::ucr_cfg_t cfg,
	output ucr_pkg::ucr_strb_t strb,
	output logic [7:0] rdata,
	output logic irq
);
	import ucr_pkg::*;
	ucr_chan_st_t st_ff, nxt_st;
	logic enh, div, unlock, fifo_on, id_sel, line_int, rx_int, tx_int, modem_int;
	logic [3:0] src;
	logic [7:0] isr_val, lsr_val, rd_val;
	// Keep locked bits of the old value unless unlocked
	function automatic logic [7:0] gated(input logic [7:0] old, input logic [7:0] val,
		input logic [7:0] mask, input logic open);
		gated = open ? val : ((val & ~mask) | (old & mask));
	endfunction : gated
	////////////////////////////////////////////////////////////////////////////
	// Decode modes and interrupt sources
	always_comb begin
		enh = st_ff.cfg.line_control == ENH_KEY; // R9
		div = st_ff.cfg.line_control[DIV_BIT]; // R9
		unlock = st_ff.cfg.enhanced_function[ENH_BIT];
		fifo_on = st_ff.cfg.fifo_control[FIFO_EN_BIT];
		id_sel = !enh && st_ff.cfg.divisor_low == RST_BYTE && st_ff.cfg.divisor_high == RST_BYTE;
		// Line errors are levels held by the receiver until it clears them
		line_int = st_ff.cfg.interrupt_enable[IEN_LINE] && (chan_in.fifo_err || |chan_in.line_err);
		rx_int = st_ff.cfg.interrupt_enable[IEN_RX] && (fifo_on ? st_ff.rxi : st_ff.dr); // R2 R3 R4
		tx_int = st_ff.cfg.interrupt_enable[IEN_TX] && chan_in.tx_empty; // R2
		modem_int = st_ff.cfg.interrupt_enable[IEN_MODEM] && |chan_in.modem[3:0]; // R2
		// Fixed priority: line, rx, tx, modem
		if (line_int) begin
			src = SRC_LINE;
		end else if (rx_int) begin
			src = SRC_RX; // R5
		end else if (tx_int) begin
			src = SRC_TX;
		end else if (modem_int) begin
			src = SRC_MODEM;
		end else begin
			src = SRC_NONE;
		end
		isr_val = {fifo_on, fifo_on, 2'b00, src}; // R2
		lsr_val = {chan_in.fifo_err, chan_in.tx_idle, chan_in.tx_empty, chan_in.line_err, st_ff.dr};
	end
	////////////////////////////////////////////////////////////////////////////
	// Read data mux; the id codes show only with a zero divisor
	always_comb begin
		case (addr)
			OFS_HOLD: rd_val = div ? (id_sel ? REVISION : st_ff.cfg.divisor_low) : chan_in.rx_data;
			OFS_IEN: rd_val = div ? (id_sel ? DEVICE_ID : st_ff.cfg.divisor_high)
				: st_ff.cfg.interrupt_enable;
			OFS_ISTAT: rd_val = enh ? st_ff.cfg.enhanced_function
				: (div ? st_ff.cfg.divisor_fraction : isr_val);
			OFS_LCTL: rd_val = st_ff.cfg.line_control;
			OFS_MCTL: rd_val = enh ? st_ff.cfg.flow_on_char_1 : st_ff.cfg.modem_control;
			OFS_LSTAT: rd_val = enh ? st_ff.cfg.flow_on_char_2 : lsr_val;
			OFS_MSTAT: rd_val = enh ? st_ff.cfg.flow_off_char_1 : chan_in.modem;
			OFS_SCR: rd_val = enh ? st_ff.cfg.flow_off_char_2 : st_ff.cfg.scratch_pad;
			default: rd_val = RST_BYTE;
		endcase
	end
	////////////////////////////////////////////////////////////////////////////
	// Next state: register writes, flags and interrupt
	always_comb begin
		nxt_st = st_ff;
		nxt_st.strb = '0;
		nxt_st.strb.wdata = wdata;
		// Push wins over an empty FIFO in the same cycle
		if (chan_in.push) begin
			nxt_st.dr = 1'b1; // R6
		end else if (chan_in.fill == FILL_EMPTY) begin
			nxt_st.dr = 1'b0; // R7
		end
		nxt_st.rxi = fifo_on && st_ff.cfg.interrupt_enable[IEN_RX]
			&& chan_in.fill >= chan_in.trig; // R3 R4
		nxt_st.irq = src != SRC_NONE; // R2
		if (rd_go) begin
			nxt_st.rdata = rd_val;
			nxt_st.strb.rx_pop = addr == OFS_HOLD && !div;
		end
		if (wr_go) begin
			case (addr)
				OFS_HOLD: begin
					if (div) begin
						nxt_st.cfg.divisor_low = wdata; // R9
					end else begin
						nxt_st.strb.tx_load = 1'b1;
					end
				end
				OFS_IEN: begin
					if (div) begin
						nxt_st.cfg.divisor_high = wdata; // R9
					end else begin
						nxt_st.cfg.interrupt_enable =
							gated(st_ff.cfg.interrupt_enable, wdata, IEN_ENH, unlock); // R8
					end
				end
				OFS_ISTAT: begin
					if (enh) begin
						nxt_st.cfg.enhanced_function = wdata; // R9
					end else if (div) begin
						if (unlock) begin
							nxt_st.cfg.divisor_fraction = wdata & FRAC_MASK; // R8 R9
						end
					end else begin
						nxt_st.cfg.fifo_control =
							gated(st_ff.cfg.fifo_control, wdata, FCTL_ENH, unlock); // R8
						nxt_st.strb.fifo_load = 1'b1;
					end
				end
				OFS_LCTL: nxt_st.cfg.line_control = wdata;
				OFS_MCTL: begin
					if (enh) begin
						nxt_st.cfg.flow_on_char_1 = wdata; // R9
					end else begin
						nxt_st.cfg.modem_control =
							gated(st_ff.cfg.modem_control, wdata, MCTL_ENH, unlock); // R8
					end
				end
				OFS_LSTAT: begin
					if (enh) begin
						nxt_st.cfg.flow_on_char_2 = wdata; // R9
					end
				end
				OFS_MSTAT: begin
					if (enh) begin
						nxt_st.cfg.flow_off_char_1 = wdata; // R9
					end
				end
				OFS_SCR: begin
					if (enh) begin
						nxt_st.cfg.flow_off_char_2 = wdata; // R9
					end else begin
						nxt_st.cfg.scratch_pad = wdata;
					end
				end
				default: nxt_st.cfg = st_ff.cfg;
			endcase
		end
	end
	// All state resets to zero, so no interrupt fires at start-up
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign cfg = st_ff.cfg;
	assign strb = st_ff.strb;
	assign rdata = st_ff.rdata;
	assign irq = st_ff.irq;
	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_trig_reached;
		fifo_on && st_ff.cfg.interrupt_enable[IEN_RX] && chan_in.fill >= chan_in.trig;
	endsequence
	sequence s_trig_missed;
		fifo_on && chan_in.fill < chan_in.trig;
	endsequence
	// Mode still on a cycle later, so a host switching it off is not a miss
	sequence s_rx_armed;
		fifo_on && st_ff.cfg.interrupt_enable[IEN_RX];
	endsequence
	a_trig_int_set: assert property (s_trig_reached ##1 s_rx_armed |-> rx_int ##1 irq) // R3
		else $error("rx trigger interrupt not raised");
	a_trig_int_drop: assert property (s_trig_missed ##1 fifo_on |-> !rx_int) // R4
		else $error("rx trigger interrupt not dropped");
	a_src_shows_rx: assert property (s_trig_reached ##1 s_rx_armed |-> // R5
		line_int || isr_val[3:0] == SRC_RX)
		else $error("status lacks rx trigger source");
	a_src_clears_rx: assert property (s_trig_missed ##1 fifo_on |-> isr_val[3:0] != SRC_RX) // R5
		else $error("status keeps stale rx source");
	a_masked_quiet: assert property (st_ff.cfg.interrupt_enable[3:0] == 4'h0 |=> !irq) // R2
		else $error("interrupt with all sources masked");
	a_ready_set: assert property (chan_in.push |=> st_ff.dr && lsr_val[0]) // R6
		else $error("data ready not set on push");
	a_ready_hold: assert property (st_ff.dr && chan_in.fill != FILL_EMPTY |=> st_ff.dr) // R7
		else $error("data ready lost with data in FIFO");
	a_ready_clear: assert property (!chan_in.push && chan_in.fill == FILL_EMPTY |=> !st_ff.dr) // R7
		else $error("data ready stuck with FIFO empty");
	a_enh_locked: assert property (wr_go && addr == OFS_IEN && !div && !unlock |=> // R8
		st_ff.cfg.interrupt_enable[7:4] == $past(st_ff.cfg.interrupt_enable[7:4]))
		else $error("locked enable bits changed");
	a_div_write: assert property (wr_go && addr == OFS_HOLD && div |=> // R9
		st_ff.cfg.divisor_low == $past(wdata))
		else $error("divisor low not written");
	a_flow_write: assert property (wr_go && addr == OFS_MCTL && enh |=> // R9
		st_ff.cfg.flow_on_char_1 == $past(wdata) && $stable(st_ff.cfg.modem_control))
		else $error("flow char write misrouted");
endmodule : ucr_chan
module ucr_top #(
	parameter logic [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
	parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire ucr_pkg::ucr_host_t host,
	output logic [7:0] d_out,
	output logic d_oe,
	input wire ucr_pkg::ucr_chan_in_t chan_in_a,
	input wire ucr_pkg::ucr_chan_in_t chan_in_b,
	output ucr_pkg::ucr_cfg_t cfg_a,
	output ucr_pkg::ucr_cfg_t cfg_b,
	output ucr_pkg::ucr_strb_t strb_a,
	output ucr_pkg::ucr_strb_t strb_b,
	output logic irq_a,
	output logic irq_b
);
	import ucr_pkg::*;
	ucr_top_st_t st_ff, nxt_st;
	logic rd_go, wr_go, sel_a, sel_b;
	logic [7:0] rdata_a, rdata_b;
	////////////////////////////////////////////////////////////////////////////
	// Three-stage pin synchroniser; strobes count once stages two and three agree
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = host;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		if (st_ff.s2.rd_n == st_ff.s3.rd_n) begin
			nxt_st.rd_lvl = st_ff.s3.rd_n;
		end
		if (st_ff.s2.wr_n == st_ff.s3.wr_n) begin
			nxt_st.wr_lvl = st_ff.s3.wr_n;
		end
	end
	// Idle high so no strobe is seen coming out of reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_ff <= '{s1: HOST_IDLE, s2: HOST_IDLE, s3: HOST_IDLE, rd_lvl: 1'b1, wr_lvl: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end
	// Leading edge of each strobe; address and data come from the same stage
	assign rd_go = st_ff.rd_lvl && st_ff.s2.rd_n == st_ff.s3.rd_n && !st_ff.s3.rd_n;
	assign wr_go = st_ff.wr_lvl && st_ff.s2.wr_n == st_ff.s3.wr_n && !st_ff.s3.wr_n;
	// Channel A wins if a broken host selects both
	assign sel_a = !st_ff.s3.cs_a_n; // R1
	assign sel_b = !st_ff.s3.cs_b_n && !sel_a; // R1
	assign d_oe = !st_ff.rd_lvl && (sel_a || sel_b);
	assign d_out = sel_a ? rdata_a : rdata_b;
	ucr_chan #(.DEVICE_ID(DEVICE_ID), .REVISION(REVISION)) u_chan_a (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.rd_go(rd_go && sel_a),
		.wr_go(wr_go && sel_a),
		.addr(st_ff.s3.addr),
		.wdata(st_ff.s3.wdata),
		.chan_in(chan_in_a),
		.cfg(cfg_a),
		.strb(strb_a),
		.rdata(rdata_a),
		.irq(irq_a)
	);
	ucr_chan #(.DEVICE_ID(DEVICE_ID), .REVISION(REVISION)) u_chan_b (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.rd_go(rd_go && sel_b),
		.wr_go(wr_go && sel_b),
		.addr(st_ff.s3.addr),
		.wdata(st_ff.s3.wdata),
		.chan_in(chan_in_b),
		.cfg(cfg_b),
		.strb(strb_b),
		.rdata(rdata_b),
		.irq(irq_b)
	);
	a_chan_excl: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_go && !st_ff.s3.cs_a_n |=> $stable(cfg_b)) // R1
		else $error("unselected channel changed");
endmodule : ucr_top
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ucr_pkg::*;
	localparam logic [7:0] DEV_ID = 8'hA5; // Arbitrary value
	localparam logic [7:0] REV_ID = 8'h3C; // Arbitrary value
	logic sys_clk;
	logic rst_n;
	ucr_host_t host;
	logic [7:0] d_out;
	logic d_oe;
	ucr_chan_in_t chan_in_a;
	ucr_chan_in_t chan_in_b;
	ucr_cfg_t cfg_a;
	ucr_cfg_t cfg_b;
	logic irq_a;
	logic irq_b;
	ucr_strb_t strb_a;
	ucr_strb_t strb_b;
	int pops = 0;
	int loads = 0;
	logic [7:0] tx_seen;
	int error_cnt;
	int num_checks;
	int seed;
	int i;
	logic oe_q;
	logic [7:0] v;
	logic [15:0] n;
	logic [15:0] notes[$];
	logic [3:0] codes[4] = '{SRC_RX, SRC_TX, SRC_LINE, SRC_MODEM};

	ucr_top #(.DEVICE_ID(DEV_ID), .REVISION(REV_ID)) ucr_top_i (.sys_clk(sys_clk),
		.rst_n(rst_n), .host(host), .d_out(d_out), .d_oe(d_oe), .chan_in_a(chan_in_a),
		.chan_in_b(chan_in_b), .cfg_a(cfg_a), .cfg_b(cfg_b), .strb_a(strb_a), .strb_b(strb_b),
		.irq_a(irq_a), .irq_b(irq_b));
	ucr_host_model ucr_host_model_i (.sys_clk(sys_clk), .host(host));

	// 100 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Notes {mask, value} before the strobe so the watcher never runs dry
	task automatic rd(input logic ch, input logic [2:0] ofs, input logic [7:0] e,
		input logic [7:0] m);
		notes.push_back({m, e & m});
		ucr_host_model_i.access(ch, 1'b0, ofs, 8'h00);
	endtask : rd
	task automatic wr(input logic ch, input logic [2:0] ofs, input logic [7:0] d);
		ucr_host_model_i.access(ch, 1'b1, ofs, d);
	endtask : wr
	// Bounded wait; a miss shows as a failed compare
	task automatic wait_irq(input logic ch, input logic e);
		int k;
		k = 0;
		while ((ch ? irq_b : irq_a) !== e && k < 6) begin
			@(negedge sys_clk);
			k++;
		end
		check({7'h0, ch ? irq_b : irq_a}, {7'h0, e});
		// A wait that ran out ends the run at once
		if ((ch ? irq_b : irq_a) !== e) wrap_up();
	endtask : wait_irq
	task automatic wrap_up();
		if (notes.size() != 0) error_cnt++;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////////////
	// Watcher: first cycle of a data drive takes the oldest note
	always @(negedge sys_clk) begin
		oe_q <= d_oe;
		if (d_oe === 1'b1 && oe_q !== 1'b1) begin
			if (notes.size() == 0) begin
				check(d_out, ~d_out);
			end else begin
				n = notes.pop_front();
				check(d_out & n[15:8], n[7:0]);
			end
		end
		// Strobes stand one cycle, so each shows at exactly one falling edge
		if (strb_a.rx_pop === 1'b1 || strb_b.rx_pop === 1'b1) pops++;
		if (strb_a.fifo_load === 1'b1) loads++;
		if (strb_b.tx_load === 1'b1) tx_seen = strb_b.wdata;
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		error_cnt = 0;
		num_checks = 0;
		seed = 32'ha451;
		rst_n = 1'b0;
		chan_in_a = '0;
		chan_in_b = '0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		check({5'h0, d_oe, irq_a, |{cfg_a, cfg_b, irq_b}}, 8'h00);
		// Channels keep separate scratch bytes
		for (i = 0; i < 2; i++) begin
			v = $random(seed);
			wr(1'b0, OFS_SCR, v);
			wr(1'b1, OFS_SCR, ~v);
			rd(1'b0, OFS_SCR, v, 8'hFF);
			rd(1'b1, OFS_SCR, ~v, 8'hFF);
		end
		// Divisor latch, identity while divisor is zero, locked fraction
		wr(1'b0, OFS_LCTL, 8'h80);
		rd(1'b0, 3'h0, REV_ID, 8'hFF);
		rd(1'b0, 3'h1, DEV_ID, 8'hFF);
		wr(1'b0, 3'h0, 8'h12);
		wr(1'b0, 3'h1, 8'h34);
		rd(1'b0, 3'h0, 8'h12, 8'hFF);
		rd(1'b0, 3'h1, 8'h34, 8'hFF);
		wr(1'b0, 3'h2, 8'h0F);
		rd(1'b0, 3'h2, 8'h00, 8'hFF);
		// Enhanced set under the key, then unlock
		wr(1'b0, OFS_LCTL, ENH_KEY);
		wr(1'b0, 3'h2, 8'h10);
		rd(1'b0, 3'h2, 8'h10, 8'hFF);
		for (i = 4; i < 8; i++) wr(1'b0, i[2:0], 8'h40 + i[7:0]);
		for (i = 4; i < 8; i++) rd(1'b0, i[2:0], 8'h40 + i[7:0], 8'hFF);
		wr(1'b0, OFS_LCTL, 8'h80);
		wr(1'b0, 3'h2, 8'hFF);
		rd(1'b0, 3'h2, 8'h3F, 8'hFF);
		wr(1'b0, OFS_LCTL, 8'h00);
		// Enhanced enable and modem bits: locked on B; enable bits open on A
		wr(1'b1, OFS_IEN, 8'hF1);
		rd(1'b1, OFS_IEN, 8'h01, 8'hFF);
		wr(1'b1, OFS_MCTL, 8'hFF);
		rd(1'b1, OFS_MCTL, 8'h1F, 8'hFF);
		wr(1'b0, OFS_IEN, 8'hF0);
		rd(1'b0, OFS_IEN, 8'hF0, 8'hFF);
		// Data ready sets on entry and survives a pop until empty
		@(posedge sys_clk);
		chan_in_b.fill <= 6'h1;
		chan_in_b.push <= 1'b1;
		chan_in_b.rx_data <= 8'h5C;
		@(posedge sys_clk);
		chan_in_b.push <= 1'b0;
		rd(1'b1, OFS_LSTAT, 8'h01, 8'h01);
		rd(1'b1, OFS_HOLD, 8'h5C, 8'hFF);
		// Only this read pops; divisor reads at offset 0 must not
		check(pops[7:0], 8'h01);
		wr(1'b1, OFS_HOLD, v);
		check(tx_seen, v);
		rd(1'b1, OFS_LSTAT, 8'h01, 8'h01);
		// Each enable alone raises irq with its own source code
		chan_in_b.tx_empty <= 1'b1;
		chan_in_b.line_err <= 4'h1;
		chan_in_b.modem <= 8'h01;
		rd(1'b1, OFS_LSTAT, 8'h23, 8'hFF);
		rd(1'b1, OFS_MSTAT, 8'h01, 8'hFF);
		for (i = 0; i < 4; i++) begin
			wr(1'b1, OFS_IEN, 8'h01 << i);
			wait_irq(1'b1, 1'b1);
			rd(1'b1, OFS_ISTAT, {4'h0, codes[i]}, 8'hFF);
		end
		wr(1'b1, OFS_IEN, 8'h00);
		wait_irq(1'b1, 1'b0);
		@(posedge sys_clk);
		chan_in_b.fill <= 6'h0;
		@(negedge sys_clk);
		rd(1'b1, OFS_LSTAT, 8'h00, 8'h01);
		// Trigger-level interrupt on A around the boundary
		wr(1'b0, OFS_ISTAT, 8'h01);
		check(loads[7:0], 8'h01);
		check(cfg_a.fifo_control, 8'h01);
		wr(1'b0, OFS_IEN, 8'h01);
		@(posedge sys_clk);
		chan_in_a.trig <= 6'h4;
		chan_in_a.fill <= 6'h3;
		repeat (3) @(posedge sys_clk);
		wait_irq(1'b0, 1'b0);
		chan_in_a.fill <= 6'h4;
		wait_irq(1'b0, 1'b1);
		rd(1'b0, OFS_ISTAT, 8'hC4, 8'hFF);
		@(posedge sys_clk);
		chan_in_a.fill <= 6'h3;
		wait_irq(1'b0, 1'b0);
		rd(1'b0, OFS_ISTAT, 8'hC1, 8'hFF);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire

// ---- verif/ucr_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ucr_host_model (
	input wire logic sys_clk,
	output ucr_pkg::ucr_host_t host
);
	import ucr_pkg::*;
	// Bus idles with both selects and strobes high
	initial host = HOST_IDLE;
	////////////////////////////////////////////////////////////////////////////////
	// One access; select, offset and data settle a cycle before the strobe
	task automatic access(input logic ch, input logic wr, input logic [2:0] ofs,
		input logic [7:0] d);
		ucr_host_t h;
		h = HOST_IDLE;
		h.cs_a_n = ch;
		h.cs_b_n = !ch;
		h.addr = ofs;
		h.wdata = wr ? d : ~host.wdata;
		@(posedge sys_clk);
		host <= h;
		@(posedge sys_clk);
		h.rd_n = wr;
		h.wr_n = !wr;
		host <= h;
		// Strobe long enough for the three-flop filter
		repeat (7) @(posedge sys_clk);
		h.rd_n = 1'b1;
		h.wr_n = 1'b1;
		host <= h;
		@(posedge sys_clk);
		// Released data pins do not keep the last byte
		host <= '{cs_a_n: 1'b1, cs_b_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: ~ofs,
			wdata: ~h.wdata};
		repeat (4) @(posedge sys_clk);
	endtask : access
endmodule : ucr_host_model
`default_nettype wire
